// File: logic/aps_top.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
// Operation
// [RL1] start source: software, timer, external pin
// [RL2] optional lock-step with main converter starts
// [RL3] completion sets flag; interrupt only if enabled
// [RL4] eight-bit result latched on completion
// [RL5] gain choice: half, one, two, four
// [RL6] shutdown stops all aux conversions
// [RL7] reference: analog supply or external pin
// [RL8] channel field picks one of eight
// [RL9] triggers no faster than 500 ksps
// [RL10] comparator interrupt on chosen edge(s)
// [RL11] comparator edges wake sleeping processor
// [RL12] comparator output state readable anytime
// [RL13] comparator output offered to crossbar
// [RL14] dac updates on write or timer overflow
// [RL15] each dac and comparator can shut down
// [RL16] two comparators, two twelve-bit dacs
// [RL17] comparator hysteresis held in configuration
// [RL18] starts ignored while busy; busy ends at latch
// [RL19] timer mode holds data until overflow
module aps_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [aps_pkg::APS_AW-1:0] addr,
  input wire logic [aps_pkg::APS_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [aps_pkg::APS_DW-1:0] rdata,
  input wire logic tmr2_ovf,
  input wire logic tmr3_ovf,
  input wire logic tmr4_ovf,
  input wire logic main_sw_start,
  input wire logic ext_start_pin,
  input wire logic [7:0] aux_data,
  input wire logic aux_eoc,
  output logic aux_start,
  output logic aux_shutdown,
  output logic [1:0] aux_gain,
  output logic aux_ref_ext,
  output logic [2:0] aux_chan,
  input wire logic [aps_pkg::APS_NCH-1:0] cmp_raw,
  output logic [aps_pkg::APS_NCH-1:0] cmp_out,
  output logic [aps_pkg::APS_NCH-1:0] cmp_xbar_en,
  output logic [aps_pkg::APS_NCH-1:0] cmp_shutdown,
  output logic [aps_pkg::APS_NCH-1:0][1:0] cmp_hyst,
  output logic [aps_pkg::APS_NCH-1:0][11:0] dac_code,
  output logic [aps_pkg::APS_NCH-1:0] dac_shutdown,
  output logic irq,
  output logic wake
);
  import aps_pkg::*;

  aps_state_s s_ff;
  aps_state_s nxt_s;

  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    unique case (aps_edge_e'(mode))
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction

  function automatic logic tmr_hit(input logic [1:0] upd, input logic t2,
                                   input logic t3, input logic t4);
    unique case (aps_upd_e'(upd))
      UPD_SW: tmr_hit = 1'b0;
      UPD_T2: tmr_hit = t2;
      UPD_T3: tmr_hit = t3;
      UPD_T4: tmr_hit = t4;
    endcase
  endfunction

  function automatic logic is_dac(input logic [APS_AW-1:0] a);
    is_dac = a[APS_AW-1] == ADR_DAC_PAGE[1];
  endfunction

  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    logic trig;
    logic go;
    logic di;
    logic [7:0] r;
    ev = '0;
    clr = '0;
    trig = 1'b0;
    go = 1'b0;
    di = addr[2];
    r = '0;
    nxt_s = s_ff;
    // pin synchronisers
    nxt_s.ext_sync = {s_ff.ext_sync[0], ext_start_pin};
    nxt_s.ext_prev = s_ff.ext_sync[1];
    nxt_s.cmp_s1 = cmp_raw;
    nxt_s.cmp_s2 = s_ff.cmp_s1;
    nxt_s.cmp_prev = s_ff.cmp_s2;
    // timer-mode dac transfers from the holding registers
    for (int i = 0; i < APS_NCH; i++) begin
      if (tmr_hit(s_ff.dac_cfg[i][DAC_UPD_L +: 2], tmr2_ovf, tmr3_ovf,
                  tmr4_ovf)) begin
        nxt_s.dac_out[i] = {s_ff.dac_hi[i], s_ff.dac_lo[i]}; // RL19 RL14
      end
    end
    // register writes
    if (wr) begin
      if (is_dac(addr)) begin
        unique case (addr[1:0])
          DAC_LO: nxt_s.dac_lo[di] = wdata;
          DAC_HI: begin
            nxt_s.dac_hi[di] = wdata[DAC_HI_W-1:0];
            if (aps_upd_e'(s_ff.dac_cfg[di][DAC_UPD_L +: 2]) == UPD_SW) begin
              nxt_s.dac_out[di] = {wdata[DAC_HI_W-1:0],
                                   s_ff.dac_lo[di]}; // RL14
            end
          end
          DAC_CTL: nxt_s.dac_cfg[di] = wdata[2:0]; // RL15
          default: ;
        endcase
      end else begin
        unique case (addr)
          ADR_AUX_CTL: begin
            nxt_s.aux_off = wdata[AUX_OFF_B]; // RL6
            nxt_s.aux_src = wdata[AUX_SRC_L +: 2]; // RL1
            trig = wdata[AUX_GO_B] &&
                   aps_src_e'(s_ff.aux_src) == SRC_SW; // RL1
          end
          ADR_AUX_CFG: begin
            nxt_s.aux_chan = wdata[CFG_CHAN_L +: 3]; // RL8
            nxt_s.aux_gain = wdata[CFG_GAIN_L +: 2]; // RL5
            nxt_s.aux_ref = wdata[CFG_REF_B]; // RL7
          end
          ADR_INT_CLR: clr = wdata[2:0];
          ADR_INT_EN: nxt_s.ien = wdata[2:0];
          ADR_CMP0_CTL: nxt_s.cmp_cfg[0] = wdata; // RL17 RL15
          ADR_CMP1_CTL: nxt_s.cmp_cfg[1] = wdata; // RL17 RL15
          default: ;
        endcase
      end
    end
    // aux conversion start selection
    unique case (aps_src_e'(s_ff.aux_src))
      SRC_SW: ;
      SRC_TMR: trig = tmr3_ovf; // RL1
      SRC_EXT: trig = s_ff.ext_sync[1] & ~s_ff.ext_prev; // RL1
      SRC_MAIN: trig = main_sw_start; // RL2
    endcase
    go = trig & ~s_ff.busy & ~s_ff.aux_off; // RL18 RL6
    nxt_s.start = go;
    nxt_s.busy = go | (s_ff.busy & ~aux_eoc); // RL18
    if (s_ff.busy && aux_eoc) begin
      nxt_s.aux_res = aux_data; // RL4
      ev[INT_AUX_B] = 1'b1; // RL3
    end
    // comparator edge events
    for (int i = 0; i < APS_NCH; i++) begin
      if (s_ff.cmp_cfg[i][CMP_EN_B]) begin
        ev[INT_CMP_L + i] = edge_hit(s_ff.cmp_cfg[i][CMP_EDGE_L +: 2],
                                     s_ff.cmp_s2[i],
                                     s_ff.cmp_prev[i]); // RL10
      end
    end
    // sticky status, set wins over clear
    nxt_s.stat = (s_ff.stat & ~clr) | ev; // RL3
    // register reads
    if (rd) begin
      if (is_dac(addr)) begin
        unique case (addr[1:0])
          DAC_LO: r = s_ff.dac_lo[di];
          DAC_HI: r[DAC_HI_W-1:0] = s_ff.dac_hi[di];
          DAC_CTL: r[2:0] = s_ff.dac_cfg[di];
          default: ;
        endcase
      end else begin
        unique case (addr)
          ADR_AUX_CTL: begin
            r[AUX_OFF_B] = s_ff.aux_off;
            r[AUX_SRC_L +: 2] = s_ff.aux_src;
            r[AUX_BUSY_B] = s_ff.busy;
          end
          ADR_AUX_CFG: begin
            r[CFG_CHAN_L +: 3] = s_ff.aux_chan;
            r[CFG_GAIN_L +: 2] = s_ff.aux_gain;
            r[CFG_REF_B] = s_ff.aux_ref;
          end
          ADR_AUX_RES: r = s_ff.aux_res; // RL4
          ADR_INT_STAT: r[2:0] = s_ff.stat;
          ADR_INT_EN: r[2:0] = s_ff.ien;
          ADR_CMP0_CTL: begin
            r = s_ff.cmp_cfg[0];
            r[CMP_OUT_B] = s_ff.cmp_s2[0]; // RL12
          end
          ADR_CMP1_CTL: begin
            r = s_ff.cmp_cfg[1];
            r[CMP_OUT_B] = s_ff.cmp_s2[1]; // RL12
          end
          default: ;
        endcase
      end
    end
    nxt_s.rdata = r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.aux_off <= AUX_OFF_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rdata;
  assign aux_start = s_ff.start;
  assign aux_shutdown = s_ff.aux_off; // RL6
  assign aux_gain = s_ff.aux_gain; // RL5
  assign aux_ref_ext = s_ff.aux_ref; // RL7
  assign aux_chan = s_ff.aux_chan; // RL8
  assign irq = |(s_ff.stat & s_ff.ien); // RL3
  // edge logic is clocked by the always-on system clock, not the cpu
  assign wake = |(s_ff.stat[INT_CMP_L +: 2] &
                  s_ff.ien[INT_CMP_L +: 2]); // RL11

  // per-channel comparator and dac outputs
  generate
    for (genvar g = 0; g < APS_NCH; g++) begin : g_ch
      assign cmp_out[g] = s_ff.cmp_s2[g]; // RL13
      assign cmp_xbar_en[g] = s_ff.cmp_cfg[g][CMP_XB_B]; // RL13
      assign cmp_shutdown[g] = ~s_ff.cmp_cfg[g][CMP_EN_B]; // RL15
      assign cmp_hyst[g] = s_ff.cmp_cfg[g][CMP_HYS_L +: 2]; // RL17
      assign dac_code[g] = s_ff.dac_out[g]; // RL16
      assign dac_shutdown[g] = ~s_ff.dac_cfg[g][DAC_EN_B]; // RL15
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_start_busy: assert property ( // RL18
    aux_start |-> s_ff.busy && !$past(s_ff.busy))
    else $error("aux start while already busy");

  a_busy_hold: assert property ( // RL18
    s_ff.busy && !aux_eoc |=> s_ff.busy && !aux_start)
    else $error("busy dropped without completion");

  a_result_latch: assert property ( // RL4
    s_ff.busy && aux_eoc |=> s_ff.aux_res == $past(aux_data)
      && s_ff.stat[INT_AUX_B] && !s_ff.busy)
    else $error("result not latched on completion");

  a_irq_level: assert property ( // RL3
    (s_ff.stat & s_ff.ien) != 3'h0 |-> irq)
    else $error("enabled event without interrupt");

  a_irq_masked: assert property ( // RL3
    (s_ff.stat & s_ff.ien) == 3'h0 |-> !irq)
    else $error("interrupt without enabled event");

  a_off_nostart: assert property ( // RL6
    $past(s_ff.aux_off) |-> !aux_start)
    else $error("start while shut down");

  a_main_sync: assert property ( // RL2
    s_ff.aux_src == SRC_MAIN && main_sw_start
      && !s_ff.busy && !s_ff.aux_off |=> aux_start)
    else $error("main converter start not followed");

  a_dac_swupd: assert property ( // RL14
    wr && is_dac(addr) && addr[1:0] == DAC_HI
      && s_ff.dac_cfg[addr[2]][2:1] == UPD_SW
      |=> dac_code[$past(addr[2])] == {$past(wdata[3:0]),
          $past(s_ff.dac_lo[addr[2]])})
    else $error("dac software update missed");

  a_dac_hold: assert property ( // RL19
    s_ff.dac_cfg[0][2:1] != UPD_SW && !tmr2_ovf && !tmr3_ovf
      && !tmr4_ovf |=> $stable(dac_code[0]))
    else $error("dac changed without overflow");

  a_cmp_rise: assert property ( // RL10
    s_ff.cmp_cfg[0][CMP_EN_B] && s_ff.cmp_cfg[0][2:1] == EDGE_RISE
      && s_ff.cmp_s2[0] && !s_ff.cmp_prev[0] |=> s_ff.stat[INT_CMP_L])
    else $error("comparator rising edge lost");

  a_start_pulse: assert property ( // RL18
    aux_start |=> !aux_start)
    else $error("start pulse longer than one cycle");

  a_busy_nostart: assert property ( // RL18
    s_ff.busy |=> !aux_start)
    else $error("start issued while busy");

  a_sw_start: assert property ( // RL1
    wr && addr == ADR_AUX_CTL && wdata[AUX_GO_B] && s_ff.aux_src == SRC_SW
      && !s_ff.busy && !s_ff.aux_off |=> aux_start)
    else $error("software start not followed");

  a_tmr_start: assert property ( // RL1
    s_ff.aux_src == SRC_TMR && tmr3_ovf && !s_ff.busy
      && !s_ff.aux_off |=> aux_start)
    else $error("timer start not followed");

  a_ext_start: assert property ( // RL1
    s_ff.aux_src == SRC_EXT && s_ff.ext_sync[1] && !s_ff.ext_prev
      && !s_ff.busy && !s_ff.aux_off |=> aux_start)
    else $error("external start not followed");

  a_res_stable: assert property ( // RL4
    !s_ff.busy |=> $stable(s_ff.aux_res))
    else $error("result changed while idle");

  a_done_sticky: assert property ( // RL3
    s_ff.stat[INT_AUX_B]
      && !(wr && addr == ADR_INT_CLR && wdata[INT_AUX_B])
      |=> s_ff.stat[INT_AUX_B])
    else $error("done flag lost without clear");

  a_done_clear: assert property ( // RL3
    wr && addr == ADR_INT_CLR && wdata[INT_AUX_B]
      && !(s_ff.busy && aux_eoc) |=> !s_ff.stat[INT_AUX_B])
    else $error("done flag not cleared");

  a_done_set: assert property ( // RL3
    !s_ff.stat[INT_AUX_B] && !(s_ff.busy && aux_eoc)
      |=> !s_ff.stat[INT_AUX_B])
    else $error("done flag set without completion");

  a_gain_out: assert property ( // RL5
    wr && addr == ADR_AUX_CFG
      |=> aux_gain == $past(wdata[CFG_GAIN_L +: 2]))
    else $error("gain setting not applied");

  a_ref_out: assert property ( // RL7
    wr && addr == ADR_AUX_CFG |=> aux_ref_ext == $past(wdata[CFG_REF_B]))
    else $error("reference setting not applied");

  a_chan_out: assert property ( // RL8
    wr && addr == ADR_AUX_CFG
      |=> aux_chan == $past(wdata[CFG_CHAN_L +: 3]))
    else $error("channel setting not applied");

  a_off_out: assert property ( // RL6
    wr && addr == ADR_AUX_CTL |=> aux_shutdown == $past(wdata[AUX_OFF_B]))
    else $error("shutdown setting not applied");

  a_wake_irq: assert property ( // RL11
    wake |-> irq)
    else $error("wake without interrupt");

  a_wake_cmp: assert property ( // RL11
    (s_ff.stat[2:1] & s_ff.ien[2:1]) != 2'h0 |-> wake)
    else $error("comparator event without wake");

  a_cmp_sync: assert property ( // RL12
    cmp_out == $past(cmp_raw, 2))
    else $error("comparator state not two cycles behind");

  a_res_read: assert property ( // RL4
    rd && addr == ADR_AUX_RES |=> rdata == $past(s_ff.aux_res))
    else $error("result read wrong");

  a_busy_read: assert property ( // RL18
    rd && addr == ADR_AUX_CTL
      |=> rdata[AUX_BUSY_B] == $past(s_ff.busy))
    else $error("busy read wrong");

  a_cmp_read: assert property ( // RL12
    rd && addr == ADR_CMP0_CTL
      |=> rdata[CMP_OUT_B] == $past(s_ff.cmp_s2[0]))
    else $error("comparator state read wrong");

  a_dac_shut: assert property ( // RL15
    wr && addr == {ADR_DAC_PAGE, DAC_CTL}
      |=> dac_shutdown[0] == !$past(wdata[DAC_EN_B]))
    else $error("dac shutdown not applied");

  a_cmp_shut: assert property ( // RL15
    wr && addr == ADR_CMP0_CTL
      |=> cmp_shutdown[0] == !$past(wdata[CMP_EN_B]))
    else $error("comparator shutdown not applied");

  a_hyst_out: assert property ( // RL17
    wr && addr == ADR_CMP1_CTL
      |=> cmp_hyst[1] == $past(wdata[CMP_HYS_L +: 2]))
    else $error("hysteresis setting not applied");

  a_xbar_out: assert property ( // RL13
    wr && addr == ADR_CMP1_CTL
      |=> cmp_xbar_en[1] == $past(wdata[CMP_XB_B]))
    else $error("crossbar enable not applied");

  a_cmp_fall: assert property ( // RL10
    s_ff.cmp_cfg[1][CMP_EN_B] && s_ff.cmp_cfg[1][2:1] == EDGE_FALL
      && !s_ff.cmp_s2[1] && s_ff.cmp_prev[1] |=> s_ff.stat[INT_CMP_L + 1])
    else $error("comparator falling edge lost");

  a_cmp_off: assert property ( // RL10
    !s_ff.cmp_cfg[0][CMP_EN_B] && !s_ff.stat[INT_CMP_L]
      |=> !s_ff.stat[INT_CMP_L])
    else $error("event from disabled comparator");

  a_dac_tmr: assert property ( // RL19
    s_ff.dac_cfg[1][2:1] == UPD_T4 && tmr4_ovf
      |=> dac_code[1] == $past({s_ff.dac_hi[1], s_ff.dac_lo[1]}))
    else $error("dac timer update missed");
endmodule

// File: logic/aps_pkg.sv
package aps_pkg;
  localparam int APS_AW = 4;
  localparam int APS_DW = 8;
  localparam int APS_NCH = 2;
  // register offsets
  localparam logic [3:0] ADR_AUX_CTL = 4'h0;
  localparam logic [3:0] ADR_AUX_CFG = 4'h1;
  localparam logic [3:0] ADR_AUX_RES = 4'h2;
  localparam logic [3:0] ADR_INT_STAT = 4'h3;
  localparam logic [3:0] ADR_INT_CLR = 4'h4;
  localparam logic [3:0] ADR_INT_EN = 4'h5;
  localparam logic [3:0] ADR_CMP0_CTL = 4'h6;
  localparam logic [3:0] ADR_CMP1_CTL = 4'h7;
  // dac n sits at 8 + 4n: low byte, high nibble, control
  localparam logic [1:0] ADR_DAC_PAGE = 2'h2;
  localparam logic [1:0] DAC_LO = 2'h0;
  localparam logic [1:0] DAC_HI = 2'h1;
  localparam logic [1:0] DAC_CTL = 2'h2;
  // field positions
  localparam int AUX_OFF_B = 0;
  localparam int AUX_SRC_L = 1;
  localparam int AUX_GO_B = 3;
  localparam int AUX_BUSY_B = 4;
  localparam int CFG_CHAN_L = 0;
  localparam int CFG_GAIN_L = 3;
  localparam int CFG_REF_B = 5;
  localparam int INT_AUX_B = 0;
  localparam int INT_CMP_L = 1;
  localparam int CMP_EN_B = 0;
  localparam int CMP_EDGE_L = 1;
  localparam int CMP_HYS_L = 3;
  localparam int CMP_XB_B = 5;
  localparam int CMP_OUT_B = 6;
  localparam int DAC_EN_B = 0;
  localparam int DAC_UPD_L = 1;
  localparam int DAC_HI_W = 4;
  // reset values
  localparam logic AUX_OFF_RST = 1'b1;

  typedef enum logic [1:0] {SRC_SW, SRC_TMR, SRC_EXT, SRC_MAIN} aps_src_e;
  typedef enum logic [1:0] {UPD_SW, UPD_T2, UPD_T3, UPD_T4} aps_upd_e;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH}
    aps_edge_e;
  typedef enum logic [1:0] {GAIN_HALF, GAIN_ONE, GAIN_TWO, GAIN_FOUR}
    aps_gain_e;

  typedef struct packed {
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [1:0] cmp_prev;
    logic aux_off;
    logic [1:0] aux_src;
    logic [2:0] aux_chan;
    logic [1:0] aux_gain;
    logic aux_ref;
    logic busy;
    logic start;
    logic [7:0] aux_res;
    logic [2:0] stat;
    logic [2:0] ien;
    logic [1:0][7:0] cmp_cfg;
    logic [1:0][7:0] dac_lo;
    logic [1:0][3:0] dac_hi;
    logic [1:0][11:0] dac_out;
    logic [1:0][2:0] dac_cfg;
    logic [7:0] rdata;
  } aps_state_s;
endpackage

// File: dv/aps_conv_model.sv
`timescale 1ns/1ns
// converter stand-in: fixed conversion time, data valid only with eoc
module aps_conv_model #(parameter int LAT = 200) (
  input wire logic clock,
  input wire logic rst,
  input wire logic aux_start,
  input wire logic [7:0] value,
  output logic aux_eoc,
  output logic [7:0] aux_data
);
  int cnt = 0;
  initial aux_eoc = 1'h0;
  // 2 us per conversion keeps starts within throughput
  always @(posedge clock) begin
    aux_eoc <= rst ? 1'h0 : (cnt == 1);
    if (rst) cnt <= 0;
    else if (aux_start) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // outside eoc the data lines carry junk
  assign aux_data = aux_eoc ? value : ~value;
endmodule

// File: dv/test_analog_peripheral_sequencer.sv
`timescale 1ns/1ns
module test_analog_peripheral_sequencer;
  import aps_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [2:0] s;
    logic [11:0] e;
  } aps_row_s;
  logic clock = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, got, conv_val = 8'h00, aux_data;
  logic [4:0] trg = 5'h00;
  logic [1:0] cmp_raw = 2'h0, aux_gain, cmp_out, cmp_xbar_en, cmp_shutdown;
  logic [1:0] dac_shutdown;
  logic [2:0] aux_chan;
  logic [1:0][1:0] cmp_hyst;
  logic [1:0][11:0] dac_code;
  logic [11:0] prev;
  logic aux_eoc, aux_start, aux_shutdown, aux_ref_ext, irq, wake;
  int fails = 0, cmp_count = 0, starts = 0, n0 = 0;
  int tmap [3] = '{0, 1, 4};
  aps_row_s rows [14] = '{
    '{4'h1, 8'h00, 3'h1, 12'h000},
    '{4'h1, 8'h0F, 3'h1, 12'h001},
    '{4'h1, 8'h0F, 3'h0, 12'h007},
    '{4'h1, 8'h32, 3'h1, 12'h002},
    '{4'h1, 8'h32, 3'h2, 12'h001},
    '{4'h1, 8'h1D, 3'h1, 12'h003},
    '{4'h1, 8'h1D, 3'h2, 12'h000},
    '{4'h1, 8'h1D, 3'h0, 12'h005},
    '{4'hA, 8'h01, 3'h5, 12'h002},
    '{4'h8, 8'hAB, 3'h3, 12'h000},
    '{4'h9, 8'h0C, 3'h3, 12'hCAB},
    '{4'hE, 8'h01, 3'h5, 12'h000},
    '{4'hC, 8'hFF, 3'h4, 12'h000},
    '{4'hD, 8'h0F, 3'h4, 12'hFFF}
  };
  aps_top dut_u (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .tmr2_ovf(trg[0]), .tmr3_ovf(trg[1]), .ext_start_pin(trg[2]),
    .main_sw_start(trg[3]), .tmr4_ovf(trg[4]), .aux_data, .aux_eoc,
    .aux_start, .aux_shutdown, .aux_gain, .aux_ref_ext, .aux_chan,
    .cmp_raw, .cmp_out, .cmp_xbar_en, .cmp_shutdown, .cmp_hyst,
    .dac_code, .dac_shutdown, .irq, .wake);
  aps_conv_model conv_u (.clock, .rst, .aux_start, .value(conv_val),
    .aux_eoc, .aux_data);
  always #5 clock = ~clock;
  always @(posedge clock) if (aux_start) starts <= starts + 1;
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    rd <= 1'h1;
    addr <= a;
    @(posedge clock);
    rd <= 1'h0;
    #1 got = rdata;
  endtask
  task automatic fire(input int b);
    @(posedge clock);
    trg <= 5'h01 << b;
    @(posedge clock);
    trg <= 5'h00;
  endtask
  function automatic logic [11:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = {9'h000, aux_chan};
      3'h1: obs = {10'h000, aux_gain};
      3'h2: obs = {11'h000, aux_ref_ext};
      3'h3: obs = dac_code[0];
      3'h4: obs = dac_code[1];
      default: obs = {10'h000, dac_shutdown};
    endcase
  endfunction
  // one conversion from a source, retriggered while busy
  task automatic conv(input logic [1:0] src, input logic [7:0] v,
                      input logic ie);
    int n;
    n = starts;
    conv_val = v;
    wr_reg(ADR_INT_EN, {7'h00, ie});
    wr_reg(ADR_AUX_CTL, {5'h00, src, 1'h0});
    for (int k = 0; k < 2; k++) begin
      if (src == SRC_SW) wr_reg(ADR_AUX_CTL, 8'h08);
      else fire(src);
      repeat (6) @(posedge clock);
      rd_reg(ADR_AUX_CTL);
      chk(got[4], 1'h1);
    end
    got = 8'h00;
    for (int i = 0; i < 150 && got[0] !== 1'h1; i++) rd_reg(ADR_INT_STAT);
    chk(got[0], 1'h1);
    chk(irq, ie);
    chk(starts - n, 12'h001);
    rd_reg(ADR_AUX_RES);
    chk(got, v);
    rd_reg(ADR_AUX_CTL);
    chk(got[4], 1'h0);
    wr_reg(ADR_INT_CLR, 8'h01);
    chk(irq, 1'h0);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1 chk({aux_shutdown, cmp_shutdown, dac_shutdown}, 12'h01F);
    rd_reg(ADR_AUX_CTL);
    chk(got, 8'h01);
    $display("test reset done");
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      chk(obs(rows[i].s), rows[i].e);
    end
    $display("test table done");
    for (int s = 0; s < 4; s++) conv(2'(s), 8'h3C + 8'(s), 1'(s));
    wr_reg(ADR_AUX_RES, 8'h55);
    rd_reg(ADR_AUX_RES);
    chk(got, 8'h3F);
    rd_reg(4'hB);
    chk(got, 8'h00);
    rd_reg(ADR_INT_CLR);
    chk(got, 8'h00);
    wr_reg(ADR_AUX_CTL, 8'h07);
    chk(aux_shutdown, 1'h1);
    n0 = starts;
    fire(3);
    repeat (5) @(posedge clock);
    chk(starts, n0);
    $display("test conversion done");
    wr_reg(ADR_INT_EN, 8'h06);
    for (int c = 0; c < 2; c++)
      for (int e = 1; e < 4; e++) begin
        wr_reg(ADR_CMP0_CTL + 4'(c), {3'h1, 2'h2, 2'(e), 1'h1});
        chk({cmp_xbar_en[c], cmp_hyst[c], cmp_shutdown[c]}, 12'h00C);
        for (int l = 1; l >= 0; l--) begin
          wr_reg(ADR_INT_CLR, 8'h06);
          @(posedge clock);
          cmp_raw[c] <= l[0];
          repeat (5) @(posedge clock);
          #1 chk({irq, wake, cmp_out[c]}, {e[1-l], e[1-l], l[0]});
          rd_reg(ADR_CMP0_CTL + 4'(c));
          chk(got[6], l[0]);
        end
      end
    $display("test comparator done");
    for (int k = 1; k < 4; k++) begin
      prev = dac_code[0];
      wr_reg(4'hA, {5'h00, 2'(k), 1'h1});
      wr_reg(4'h8, 8'(k * 17));
      wr_reg(4'h9, 8'(k));
      fire(tmap[k % 3]);
      #1 chk(dac_code[0], prev);
      fire(tmap[k - 1]);
      @(posedge clock);
      #1 chk(dac_code[0], {4'(k), 8'(k * 17)});
    end
    $display("test dac done");
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1 chk({aux_shutdown, cmp_shutdown, dac_shutdown}, 12'h01F);
    chk(dac_code[0], 12'h000);
    chk(irq, 1'h0);
    $display("test second reset done");
    give_verdict;
  end
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule
